// ===== hdl/serr_error_message_gating.sv
// error-event gate that raises system-error messages on the hub link
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
// Behaviour
// - errors reported only as hub messages
// - send needs global and event enable
// - one occurrence gives exactly one message
// - enable register, offset CBh, reset 00h (the code maps it at byte address 32Ch)
// - bit 5 reports refresh overrun
// - graphics-space enable acts as bit 5
// - bit 4 reports hub target abort
// - bit 3 reports locked non-DRAM access
// - bit 2 reports access outside aperture
// - bit 1 reports outside, legacy or above top
// - bit 0 reports invalid translation entry
// - events set status 14, abort sets 12
// - bridge parity gated, sets status 14, 15
// - bridge abort gated, sets status 14, 12
// - bridge global enable off blocks bridge messages
module serr_error_message_gating (
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // register bus write
   input wire logic [11:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // register bus read
   input wire logic [11:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // error events
   input wire logic AGP_MODE,
   input wire logic GFX_REFRESH_REPORT_EN,
   input wire logic REFRESH_OVERRUN,
   input wire logic HUB_TARGET_ABORT,
   input wire logic LOCKED_NON_DRAM,
   input wire logic OUTSIDE_APERTURE,
   input wire logic [31:0] AGP_ACCESS_ADDR,
   input wire logic [31:0] TOP_OF_MEMORY,
   input wire logic BAD_TRANSLATION_ENTRY,
   input wire logic BRIDGE_PARITY_ERROR,
   input wire logic BRIDGE_TARGET_ABORT,
   // hub message port
   output logic SERR_MSG_VALID,
   output logic [2:0] SERR_MSG_SOURCE,
   input wire logic SERR_MSG_READY
);
   logic [7:0] error_report_enable_q;
   logic f0_serr_en_q;
   logic f0_sig_serr_q;
   logic f0_rx_tabort_q;
   logic br_serr_en_q;
   logic br_parity_en_q;
   logic br_tabort_en_q;
   logic br_sig_serr_q;
   logic br_parity_q;
   logic br_rx_tabort_q;
   logic [6:0] pend_q;
   logic [6:0] pend_d;
   logic [6:0] fire;
   logic [6:0] sent;
   logic [7:0] en_eff;
   logic aw_have_q;
   logic aw_have_d;
   logic w_have_q;
   logic w_have_d;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic [31:0] rd_word;
   logic rd_ok;

   function automatic logic mapped(input logic [11:0] a);
      return a == serr_gate_pkg::ERR_EN_ADDR || a == serr_gate_pkg::F0_CMD_ADDR
         || a == serr_gate_pkg::F0_STS_ADDR || a == serr_gate_pkg::BR_CMD_ADDR
         || a == serr_gate_pkg::BR_STS_ADDR || a == serr_gate_pkg::BR_CTL_ADDR
         || a == serr_gate_pkg::BR_ERR_ADDR || a == serr_gate_pkg::PEND_ADDR;
   endfunction

   function automatic logic bad_range(input logic [31:0] a, input logic [31:0] tom);
      return (a >= serr_gate_pkg::LEGACY_LO && a < serr_gate_pkg::LEGACY_HI) || a >= tom;
   endfunction

   function automatic logic wr_to(input logic [11:0] a);
      return do_write && awaddr_q == a;
   endfunction

   // ----------------------------------------
   // event gating
   // ----------------------------------------
   always_comb begin
      en_eff = AGP_MODE ? error_report_enable_q : 8'h00;
      fire = '0;
      fire[serr_gate_pkg::SRC_REFRESH] = REFRESH_OVERRUN && f0_serr_en_q
         && (en_eff[serr_gate_pkg::REFRESH_BIT] || GFX_REFRESH_REPORT_EN);
      fire[serr_gate_pkg::SRC_HUB_TABORT] = HUB_TARGET_ABORT && f0_serr_en_q
         && en_eff[serr_gate_pkg::HUB_TABORT_BIT];
      fire[serr_gate_pkg::SRC_LOCK] = LOCKED_NON_DRAM && f0_serr_en_q
         && en_eff[serr_gate_pkg::LOCK_BIT];
      fire[serr_gate_pkg::SRC_APERTURE] = OUTSIDE_APERTURE && f0_serr_en_q
         && (en_eff[serr_gate_pkg::OUT_APER_BIT]
         || (en_eff[serr_gate_pkg::INV_AGP_BIT]
         && bad_range(AGP_ACCESS_ADDR, TOP_OF_MEMORY)));
      fire[serr_gate_pkg::SRC_BAD_ENTRY] = BAD_TRANSLATION_ENTRY && f0_serr_en_q
         && en_eff[serr_gate_pkg::BAD_ENTRY_BIT];
      fire[serr_gate_pkg::SRC_BR_PARITY] = BRIDGE_PARITY_ERROR && br_serr_en_q
         && br_parity_en_q;
      fire[serr_gate_pkg::SRC_BR_TABORT] = BRIDGE_TARGET_ABORT && br_serr_en_q
         && br_tabort_en_q;
   end

   // ----------------------------------------
   // pending messages
   // ----------------------------------------
   always_comb begin
      pend_d = (pend_q & ~sent) | fire;
      if (!f0_serr_en_q) begin
         pend_d[4:0] = 5'h00;
      end
      if (!br_serr_en_q) begin
         pend_d[6:5] = 2'h0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         pend_q <= '0;
      end else begin
         pend_q <= pend_d;
      end
   end

   serr_msg_sender #(
      .NUM_SRC(serr_gate_pkg::NUM_SRC),
      .SRC_W(serr_gate_pkg::SRC_W)
   ) u_sender (
      .clk(CLK),
      .srst(SRST),
      .pending(pend_q),
      .msg_ready(SERR_MSG_READY),
      .msg_valid(SERR_MSG_VALID),
      .msg_src(SERR_MSG_SOURCE),
      .sent(sent)
   );

   // ----------------------------------------
   // write channel capture
   // ----------------------------------------
   assign do_write = aw_have_q && w_have_q && !BVALID;
   assign aw_have_d = (AWVALID && AWREADY) || (aw_have_q && !do_write);
   assign w_have_d = (WVALID && WREADY) || (w_have_q && !do_write);

   always_ff @(posedge CLK) begin
      if (SRST) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         AWREADY <= !aw_have_d;
         WREADY <= !w_have_d;
         if (AWVALID && AWREADY) begin
            awaddr_q <= AWADDR;
         end
         if (WVALID && WREADY) begin
            wdata_q <= WDATA;
            wstrb_q <= WSTRB;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         BVALID <= 1'b0;
         BRESP <= serr_gate_pkg::RESP_OKAY;
      end else if (do_write) begin
         BVALID <= 1'b1;
         BRESP <= mapped(awaddr_q) ? serr_gate_pkg::RESP_OKAY : serr_gate_pkg::RESP_DECERR;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   // ----------------------------------------
   // enable registers
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SRST) begin
         error_report_enable_q <= serr_gate_pkg::ERR_EN_RST;
      end else if (wr_to(serr_gate_pkg::ERR_EN_ADDR) && wstrb_q[0] && AGP_MODE) begin
         error_report_enable_q <= wdata_q[7:0] & serr_gate_pkg::ERR_EN_MASK;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         f0_serr_en_q <= 1'b0;
         br_serr_en_q <= 1'b0;
         br_parity_en_q <= 1'b0;
         br_tabort_en_q <= 1'b0;
      end else begin
         if (wr_to(serr_gate_pkg::F0_CMD_ADDR) && wstrb_q[1]) begin
            f0_serr_en_q <= wdata_q[serr_gate_pkg::SYSERR_EN_BIT];
         end
         if (wr_to(serr_gate_pkg::BR_CMD_ADDR) && wstrb_q[1]) begin
            br_serr_en_q <= wdata_q[serr_gate_pkg::SYSERR_EN_BIT];
         end
         if (wr_to(serr_gate_pkg::BR_CTL_ADDR) && wstrb_q[0]) begin
            br_parity_en_q <= wdata_q[serr_gate_pkg::BCTL_PARITY_SERR_BIT];
         end
         if (wr_to(serr_gate_pkg::BR_ERR_ADDR) && wstrb_q[0]) begin
            br_tabort_en_q <= wdata_q[serr_gate_pkg::BERR_TABORT_BIT];
         end
      end
   end

   // ----------------------------------------
   // status flags, set wins over clear
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SRST) begin
         f0_sig_serr_q <= 1'b0;
         f0_rx_tabort_q <= 1'b0;
      end else begin
         if (wr_to(serr_gate_pkg::F0_STS_ADDR) && wstrb_q[1]) begin
            if (wdata_q[serr_gate_pkg::STS_SIG_SERR_BIT]) begin
               f0_sig_serr_q <= 1'b0;
            end
            if (wdata_q[serr_gate_pkg::STS_RX_TABORT_BIT]) begin
               f0_rx_tabort_q <= 1'b0;
            end
         end
         if (|fire[4:0]) begin
            f0_sig_serr_q <= 1'b1;
         end
         if (fire[serr_gate_pkg::SRC_HUB_TABORT]) begin
            f0_rx_tabort_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         br_sig_serr_q <= 1'b0;
         br_parity_q <= 1'b0;
         br_rx_tabort_q <= 1'b0;
      end else begin
         if (wr_to(serr_gate_pkg::BR_STS_ADDR) && wstrb_q[1]) begin
            if (wdata_q[serr_gate_pkg::STS_SIG_SERR_BIT]) begin
               br_sig_serr_q <= 1'b0;
            end
            if (wdata_q[serr_gate_pkg::STS_PARITY_BIT]) begin
               br_parity_q <= 1'b0;
            end
            if (wdata_q[serr_gate_pkg::STS_RX_TABORT_BIT]) begin
               br_rx_tabort_q <= 1'b0;
            end
         end
         if (|fire[6:5]) begin
            br_sig_serr_q <= 1'b1;
         end
         if (fire[serr_gate_pkg::SRC_BR_PARITY]) begin
            br_parity_q <= 1'b1;
         end
         if (fire[serr_gate_pkg::SRC_BR_TABORT]) begin
            br_rx_tabort_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   always_comb begin
      rd_word = '0;
      rd_ok = 1'b1;
      unique case (ARADDR)
         serr_gate_pkg::ERR_EN_ADDR: rd_word[7:0] = en_eff;
         serr_gate_pkg::F0_CMD_ADDR: rd_word[serr_gate_pkg::SYSERR_EN_BIT] = f0_serr_en_q;
         serr_gate_pkg::F0_STS_ADDR: begin
            rd_word[serr_gate_pkg::STS_SIG_SERR_BIT] = f0_sig_serr_q;
            rd_word[serr_gate_pkg::STS_RX_TABORT_BIT] = f0_rx_tabort_q;
         end
         serr_gate_pkg::BR_CMD_ADDR: rd_word[serr_gate_pkg::SYSERR_EN_BIT] = br_serr_en_q;
         serr_gate_pkg::BR_STS_ADDR: begin
            rd_word[serr_gate_pkg::STS_SIG_SERR_BIT] = br_sig_serr_q;
            rd_word[serr_gate_pkg::STS_PARITY_BIT] = br_parity_q;
            rd_word[serr_gate_pkg::STS_RX_TABORT_BIT] = br_rx_tabort_q;
         end
         serr_gate_pkg::BR_CTL_ADDR: rd_word[serr_gate_pkg::BCTL_PARITY_SERR_BIT] = br_parity_en_q;
         serr_gate_pkg::BR_ERR_ADDR: rd_word[serr_gate_pkg::BERR_TABORT_BIT] = br_tabort_en_q;
         serr_gate_pkg::PEND_ADDR: rd_word[6:0] = pend_q;
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= '0;
         RRESP <= serr_gate_pkg::RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b1;
         RDATA <= rd_word;
         RRESP <= rd_ok ? serr_gate_pkg::RESP_OKAY : serr_gate_pkg::RESP_DECERR;
      end else if (RVALID && RREADY) begin
         RVALID <= 1'b0;
         ARREADY <= 1'b1;
      end else if (!RVALID) begin
         ARREADY <= 1'b1;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   sequence s_idle_pending;
      |pend_q && !SERR_MSG_VALID;
   endsequence

   a_no_global_f0: assert property (!f0_serr_en_q |=> pend_q[4:0] == 5'h00)
      else $error("function 0 message pending while globally disabled");
   a_refresh_pend: assert property (REFRESH_OVERRUN && f0_serr_en_q
      && (en_eff[serr_gate_pkg::REFRESH_BIT] || GFX_REFRESH_REPORT_EN)
      |=> pend_q[serr_gate_pkg::SRC_REFRESH])
      else $error("refresh overrun not queued");
   a_reserved_zero: assert property (error_report_enable_q[7:6] == 2'h0)
      else $error("reserved enable bits set");
   a_f0_status: assert property (HUB_TARGET_ABORT && f0_serr_en_q
      && en_eff[serr_gate_pkg::HUB_TABORT_BIT] |=> f0_sig_serr_q && f0_rx_tabort_q)
      else $error("function 0 status not set");
   a_br_parity: assert property (BRIDGE_PARITY_ERROR && br_serr_en_q
      && br_parity_en_q
      |=> br_parity_q && br_sig_serr_q && pend_q[serr_gate_pkg::SRC_BR_PARITY])
      else $error("bridge parity not reported");
   a_br_tabort: assert property (BRIDGE_TARGET_ABORT && br_serr_en_q
      && br_tabort_en_q
      |=> br_rx_tabort_q && br_sig_serr_q)
      else $error("bridge target abort not reported");
   a_br_off: assert property (!br_serr_en_q |=> pend_q[6:5] == 2'h0)
      else $error("bridge message pending while disabled");
   a_msg_pending: assert property (SERR_MSG_VALID && $rose(SERR_MSG_VALID)
      |-> ($past(pend_q) & (7'h01 << SERR_MSG_SOURCE)) != 7'h00)
      else $error("message offered for a source not pending");
   a_offer_soon: assert property (s_idle_pending |=> SERR_MSG_VALID)
      else $error("pending message not offered");
   a_write_resp: assert property (aw_have_q && w_have_q && !BVALID |=> BVALID)
      else $error("write response missing");
endmodule // serr_error_message_gating

// ===== hdl/serr_gate_pkg.sv
// constants for the system-error message gate
package serr_gate_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] ERR_EN_IDX = 12'h0CB;
   localparam logic [11:0] ERR_EN_ADDR = {ERR_EN_IDX[9:0], 2'b00};
   localparam logic [11:0] F0_CMD_ADDR = 12'h000;
   localparam logic [11:0] F0_STS_ADDR = 12'h004;
   localparam logic [11:0] BR_CMD_ADDR = 12'h100;
   localparam logic [11:0] BR_STS_ADDR = 12'h104;
   localparam logic [11:0] BR_CTL_ADDR = 12'h108;
   localparam logic [11:0] BR_ERR_ADDR = 12'h10C;
   localparam logic [11:0] PEND_ADDR = 12'h200;
   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int SYSERR_EN_BIT = 8;
   localparam int STS_SIG_SERR_BIT = 14;
   localparam int STS_RX_TABORT_BIT = 12;
   localparam int STS_PARITY_BIT = 15;
   localparam int BCTL_PARITY_SERR_BIT = 2;
   localparam int BERR_TABORT_BIT = 0;
   localparam int REFRESH_BIT = 5;
   localparam int HUB_TABORT_BIT = 4;
   localparam int LOCK_BIT = 3;
   localparam int OUT_APER_BIT = 2;
   localparam int INV_AGP_BIT = 1;
   localparam int BAD_ENTRY_BIT = 0;
   localparam logic [7:0] ERR_EN_RST = 8'h00;
   localparam logic [7:0] ERR_EN_MASK = 8'h3F;
   localparam logic [31:0] LEGACY_LO = 32'h000A0000;
   localparam logic [31:0] LEGACY_HI = 32'h00100000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // ----------------------------------------
   // message sources, lowest code wins
   // ----------------------------------------
   localparam int NUM_SRC = 7;
   localparam int SRC_W = 3;
   typedef enum logic [2:0] {
      SRC_REFRESH = 3'h0,
      SRC_HUB_TABORT = 3'h1,
      SRC_LOCK = 3'h2,
      SRC_APERTURE = 3'h3,
      SRC_BAD_ENTRY = 3'h4,
      SRC_BR_PARITY = 3'h5,
      SRC_BR_TABORT = 3'h6
   } src_type;
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } state_type;
endpackage

// ===== hdl/serr_msg_sender.sv
// one-at-a-time sender of pending error messages
`timescale 1ns/10ps
module serr_msg_sender #(
   parameter int NUM_SRC = 7,
   parameter int SRC_W = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pending sources and link side
   input wire logic [NUM_SRC-1:0] pending,
   input wire logic msg_ready,
   output logic msg_valid,
   output logic [SRC_W-1:0] msg_src,
   output logic [NUM_SRC-1:0] sent
);
   serr_gate_pkg::state_type state_q;

   function automatic logic [SRC_W-1:0] pick(input logic [NUM_SRC-1:0] p);
      logic [SRC_W-1:0] r;
      r = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (p[i]) begin
            r = SRC_W'(i);
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // offer, hold until taken
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= serr_gate_pkg::ST_IDLE;
         msg_valid <= 1'b0;
         msg_src <= '0;
      end else begin
         unique case (state_q)
            serr_gate_pkg::ST_IDLE: begin
               if (|pending) begin
                  msg_src <= pick(pending);
                  msg_valid <= 1'b1;
                  state_q <= serr_gate_pkg::ST_SEND;
               end
            end
            serr_gate_pkg::ST_SEND: begin
               if (msg_ready) begin
                  msg_valid <= 1'b0;
                  state_q <= serr_gate_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   always_comb begin
      sent = '0;
      if (msg_valid && msg_ready) begin
         sent[msg_src] = 1'b1;
      end
   end

   a_valid_hold: assert property (@(posedge clk) disable iff (srst)
      msg_valid && !msg_ready |=> msg_valid && $stable(msg_src))
      else $error("message dropped before taken");
   a_gap_after: assert property (@(posedge clk) disable iff (srst)
      msg_valid && msg_ready |=> !msg_valid)
      else $error("messages sent back to back");
endmodule // serr_msg_sender

// ===== tb/hub_msg_model.sv
// hub-side receiver of system-error messages
`timescale 1ns/10ps
module hub_msg_model (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // message link
   input wire logic msg_valid,
   input wire logic [2:0] msg_src,
   output logic msg_ready,
   // bench control and record
   input wire logic stall,
   output logic [7:0] got_cnt,
   output logic [20:0] got_log
);
   // ----------------------------------------
   // acceptance
   // ----------------------------------------
   // prompt when free, refuses while stalled; takes no side-band reports
   always_ff @(posedge clk) begin
      if (srst) begin
         msg_ready <= 1'h0;
      end else begin
         msg_ready <= !stall;
      end
   end
   // ----------------------------------------
   // record of taken messages
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         got_cnt <= 8'h00;
         got_log <= 21'h000000;
      end else if (msg_valid && msg_ready) begin
         got_cnt <= got_cnt + 8'h01;
         got_log <= {got_log[17:0], msg_src};
      end
   end
endmodule // hub_msg_model

// ===== tb/tb_serr_error_message_gating.sv
// self-checking bench for the system-error message gate
`timescale 1ns/10ps
module tb_serr_error_message_gating;
   typedef struct packed {
      logic [2:0] ev;
      logic [1:0] ctl;
      logic [7:0] en;
      logic [31:0] addr;
      logic hit;
      logic [15:0] f0s;
      logic [15:0] brs;
   } row_type;
   localparam int NR = 18;
   localparam int LIMIT = 4000;
   logic CLK, SRST, AWVALID, WVALID, ARVALID, AGP_MODE, GFX_EN, stall;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, MSG_VALID, MSG_READY;
   logic [11:0] AWADDR, ARADDR;
   logic [3:0] WSTRB;
   logic [31:0] WDATA, AGP_ADDR, RDATA, rdat;
   logic [1:0] BRESP, RRESP, rs;
   logic [6:0] evs;
   logic [2:0] MSG_SRC;
   logic [7:0] got_cnt, base;
   logic [20:0] got_log;
   int bad_count, n_compared, cyc;
   logic [11:0] ra [8] = '{serr_gate_pkg::ERR_EN_ADDR, serr_gate_pkg::F0_CMD_ADDR,
      serr_gate_pkg::F0_STS_ADDR, serr_gate_pkg::BR_CMD_ADDR, serr_gate_pkg::BR_STS_ADDR,
      serr_gate_pkg::BR_CTL_ADDR, serr_gate_pkg::BR_ERR_ADDR, serr_gate_pkg::PEND_ADDR};
   // ev, global/gfx, enables (7:6 bridge), address, hit, func0 status, bridge status
   row_type rows [NR] = '{
      '{3'h0, 2'h2, 8'h20, 32'h0, 1'h1, 16'h4000, 16'h0},
      '{3'h0, 2'h2, 8'hDF, 32'h0, 1'h0, 16'h0000, 16'h0},
      '{3'h0, 2'h0, 8'h20, 32'h0, 1'h0, 16'h0000, 16'h0},
      '{3'h0, 2'h3, 8'h00, 32'h0, 1'h1, 16'h4000, 16'h0},
      '{3'h1, 2'h2, 8'h10, 32'h0, 1'h1, 16'h5000, 16'h0},
      '{3'h1, 2'h2, 8'h2F, 32'h0, 1'h0, 16'h0000, 16'h0},
      '{3'h2, 2'h2, 8'h08, 32'h0, 1'h1, 16'h4000, 16'h0},
      '{3'h3, 2'h2, 8'h04, 32'h00100000, 1'h1, 16'h4000, 16'h0},
      '{3'h3, 2'h2, 8'h02, 32'h00100000, 1'h0, 16'h0000, 16'h0},
      '{3'h3, 2'h2, 8'h02, 32'h0009FFFF, 1'h0, 16'h0000, 16'h0},
      '{3'h3, 2'h2, 8'h02, 32'h000A0000, 1'h1, 16'h4000, 16'h0},
      '{3'h3, 2'h2, 8'h02, 32'h10000000, 1'h1, 16'h4000, 16'h0},
      '{3'h3, 2'h2, 8'h06, 32'h000FFFFF, 1'h1, 16'h4000, 16'h0},
      '{3'h4, 2'h2, 8'h01, 32'h0, 1'h1, 16'h4000, 16'h0},
      '{3'h5, 2'h2, 8'h40, 32'h0, 1'h1, 16'h0000, 16'hC000},
      '{3'h5, 2'h0, 8'h40, 32'h0, 1'h0, 16'h0000, 16'h0},
      '{3'h6, 2'h2, 8'h80, 32'h0, 1'h1, 16'h0000, 16'h5000},
      '{3'h6, 2'h0, 8'h80, 32'h0, 1'h0, 16'h0000, 16'h0}
   };
   // ----------------------------------------
   // design and hub model
   // ----------------------------------------
   serr_error_message_gating serr_error_message_gating_i (
      .CLK(CLK), .SRST(SRST),
      .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(1'h1),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
      .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(1'h1),
      .AGP_MODE(AGP_MODE), .GFX_REFRESH_REPORT_EN(GFX_EN),
      .REFRESH_OVERRUN(evs[0]), .HUB_TARGET_ABORT(evs[1]), .LOCKED_NON_DRAM(evs[2]),
      .OUTSIDE_APERTURE(evs[3]), .AGP_ACCESS_ADDR(AGP_ADDR), .TOP_OF_MEMORY(32'h10000000),
      .BAD_TRANSLATION_ENTRY(evs[4]), .BRIDGE_PARITY_ERROR(evs[5]),
      .BRIDGE_TARGET_ABORT(evs[6]),
      .SERR_MSG_VALID(MSG_VALID), .SERR_MSG_SOURCE(MSG_SRC), .SERR_MSG_READY(MSG_READY));
   hub_msg_model hub_msg_model_i (
      .clk(CLK), .srst(SRST), .msg_valid(MSG_VALID), .msg_src(MSG_SRC),
      .msg_ready(MSG_READY), .stall(stall), .got_cnt(got_cnt), .got_log(got_log));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task end_of_test;
      if (bad_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task axi_wr(input logic [11:0] a, input logic [31:0] d);
      logic aw, w, b;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      aw = 1'h1;
      w = 1'h1;
      b = 1'h0;
      while (!b) begin
         @(posedge CLK);
         if (aw && AWREADY) begin
            aw = 1'h0;
            AWVALID <= 1'h0;
         end
         if (w && WREADY) begin
            w = 1'h0;
            WVALID <= 1'h0;
         end
         if (BVALID) begin
            b = 1'h1;
            rs = BRESP;
         end
      end
   endtask
   task axi_rd(input logic [11:0] a);
      logic ar, r;
      ARADDR <= a;
      ARVALID <= 1'h1;
      ar = 1'h1;
      r = 1'h0;
      while (!r) begin
         @(posedge CLK);
         if (ar && ARREADY) begin
            ar = 1'h0;
            ARVALID <= 1'h0;
         end
         if (RVALID) begin
            r = 1'h1;
            rdat = RDATA;
            rs = RRESP;
         end
      end
   endtask
   task pulse(input logic [6:0] v);
      @(posedge CLK);
      evs <= v;
      @(posedge CLK);
      evs <= 7'h00;
   endtask
   task settle(input logic [7:0] t);
      int k;
      k = 0;
      while (got_cnt !== t && k < 16) begin
         @(posedge CLK);
         k++;
      end
      repeat (4) @(posedge CLK);
   endtask
   task setup(input logic g, input logic [7:0] en);
      axi_wr(serr_gate_pkg::F0_CMD_ADDR, {23'h0, g, 8'h00});
      axi_wr(serr_gate_pkg::BR_CMD_ADDR, {23'h0, g, 8'h00});
      axi_wr(serr_gate_pkg::ERR_EN_ADDR, {24'h0, en});
      axi_wr(serr_gate_pkg::BR_CTL_ADDR, {29'h0, en[6], 2'h0});
      axi_wr(serr_gate_pkg::BR_ERR_ADDR, {31'h0, en[7]});
   endtask
   task clr_sts;
      axi_wr(serr_gate_pkg::F0_STS_ADDR, 32'h0000FFFF);
      axi_wr(serr_gate_pkg::BR_STS_ADDR, 32'h0000FFFF);
   endtask
   // ----------------------------------------
   // clock, timeout and sequence
   // ----------------------------------------
   always #20 CLK = ~CLK;
   always @(posedge CLK) begin
      cyc++;
      if (cyc == LIMIT) begin
         bad_count++;
         end_of_test;
      end
   end
   initial begin
      CLK = 1'h0;
      SRST = 1'h1;
      AWADDR = 12'h0;
      ARADDR = 12'h0;
      WDATA = 32'h0;
      WSTRB = 4'hF;
      AWVALID = 1'h0;
      WVALID = 1'h0;
      ARVALID = 1'h0;
      AGP_MODE = 1'h1;
      GFX_EN = 1'h0;
      AGP_ADDR = 32'h0;
      evs = 7'h00;
      stall = 1'h0;
      bad_count = 0;
      n_compared = 0;
      cyc = 0;
      repeat (8) @(posedge CLK);
      SRST <= 1'h0;
      for (int i = 0; i < 8; i++) begin
         axi_rd(ra[i]);
         chk("reset value", 32'h0, rdat);
      end
      for (int i = 0; i < NR; i++) begin
         setup(rows[i].ctl[1], rows[i].en);
         GFX_EN <= rows[i].ctl[0];
         AGP_ADDR <= rows[i].addr;
         axi_rd(serr_gate_pkg::ERR_EN_ADDR);
         chk("error_report_enable", {24'h0, rows[i].en & 8'h3F}, rdat);
         base = got_cnt;
         pulse(7'h01 << rows[i].ev);
         settle(base + {7'h0, rows[i].hit});
         chk("message count", {31'h0, rows[i].hit}, {24'h0, got_cnt - base});
         if (rows[i].hit) begin
            chk("message source", {29'h0, rows[i].ev}, {29'h0, got_log[2:0]});
         end
         axi_rd(serr_gate_pkg::F0_STS_ADDR);
         chk("func0 status", {16'h0, rows[i].f0s}, rdat);
         axi_rd(serr_gate_pkg::BR_STS_ADDR);
         chk("bridge status", {16'h0, rows[i].brs}, rdat);
         clr_sts;
      end
      // all events at once with the hub stalled
      stall <= 1'h1;
      GFX_EN <= 1'h0;
      setup(1'h1, 8'hFF);
      AGP_ADDR <= 32'h000A0000;
      base = got_cnt;
      pulse(7'h7F);
      repeat (4) @(posedge CLK);
      chk("offered source", 32'h0, {29'h0, MSG_SRC});
      chk("offer held", 32'h1, {31'h0, MSG_VALID});
      axi_rd(serr_gate_pkg::PEND_ADDR);
      chk("pending", 32'h7F, rdat);
      stall <= 1'h0;
      settle(base + 8'h07);
      chk("message count", 32'h7, {24'h0, got_cnt - base});
      chk("message order", 32'h000A72E, {11'h0, got_log});
      axi_rd(serr_gate_pkg::F0_STS_ADDR);
      chk("func0 status", 32'h5000, rdat);
      axi_rd(serr_gate_pkg::BR_STS_ADDR);
      chk("bridge status", 32'hD000, rdat);
      clr_sts;
      // outside the graphics mode the enables read zero and gate nothing
      AGP_MODE <= 1'h0;
      axi_rd(serr_gate_pkg::ERR_EN_ADDR);
      chk("error_report_enable", 32'h0, rdat);
      base = got_cnt;
      pulse(7'h01);
      settle(base);
      chk("message count", 32'h0, {24'h0, got_cnt - base});
      AGP_MODE <= 1'h1;
      // unmapped place
      axi_wr(12'h3F0, 32'hFFFFFFFF);
      chk("write response", {30'h0, serr_gate_pkg::RESP_DECERR}, {30'h0, rs});
      axi_rd(12'h3F0);
      chk("read response", {30'h0, serr_gate_pkg::RESP_DECERR}, {30'h0, rs});
      chk("read data", 32'h0, rdat);
      // write that misses the field's byte lane
      WSTRB <= 4'hE;
      axi_wr(serr_gate_pkg::ERR_EN_ADDR, 32'h0);
      WSTRB <= 4'hF;
      axi_rd(serr_gate_pkg::ERR_EN_ADDR);
      chk("error_report_enable", 32'h3F, rdat);
      // reset in mid-run with a message on offer
      stall <= 1'h1;
      pulse(7'h01);
      repeat (2) @(posedge CLK);
      SRST <= 1'h1;
      repeat (2) @(posedge CLK);
      SRST <= 1'h0;
      stall <= 1'h0;
      axi_rd(serr_gate_pkg::ERR_EN_ADDR);
      chk("error_report_enable", 32'h0, rdat);
      axi_rd(serr_gate_pkg::PEND_ADDR);
      chk("pending", 32'h0, rdat);
      chk("offer after reset", 32'h0, {31'h0, MSG_VALID});
      end_of_test;
   end
endmodule // tb_serr_error_message_gating
